// ==== include/oag_pkg.sv ====
// Purpose: constants for the operand address generator
// Assumes: 16-bit byte-addressed memory, word-aligned workspace
// Notes: mode codes follow the two-bit addressing field plus special uses
// How it works
// - register mode: workspace register contents are the operand, operand address is the register location
// - register indirect: register contents are the operand memory address
// - indexed: extension word plus register; register zero means direct instead
// - direct: extension word used unchanged as operand address
// - auto-increment: access at register address, then add two (word) or one (byte)
// - immediate: extension word is the operand value itself
// - jump: signed 8-bit displacement, doubled, added to updated program counter
// - bit i/o: displacement added to current base address selects the bit
// - monitor rom decoded from fc00, read/write memory from 0000
// - thirty-two bit i/o, sixteen in and sixteen out; clock may feed input two
package oag_pkg;
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_IDX = 2'h2;
  localparam logic [1:0] MODE_INC = 2'h3;
  localparam logic [15:0] ROM_BASE = 16'hfc00;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [3:0] CLOCK_BIT = 4'h2;
  localparam logic [3:0] REG_ZERO = 4'h0;
  typedef enum logic [2:0] {
    OAG_IDLE, OAG_RDREG, OAG_RDEXT, OAG_WBREG, OAG_DONE
  } oag_state_e;
endpackage

// ==== rtl/oag_operand_address_generator.sv ====
// Purpose: effective address formation between decode and memory bus
// Assumes: memory answers a read with rd_valid one or more cycles later; monitor
//   software handles the terminal dialogue
// Notes: one request at a time; busy while a request is open
`timescale 1ns/1ps
module oag_operand_address_generator #(
  parameter int IO_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req,
  input wire logic [1:0] mode,
  input wire logic [3:0] reg_sel,
  input wire logic byte_op,
  input wire logic immediate,
  input wire logic jump,
  input wire logic bit_io,
  input wire logic [7:0] relative_offset,
  input wire logic [15:0] workspace_ptr,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] base_addr,
  output logic busy,
  output logic done,
  output logic addr_valid,
  output logic [15:0] operand_addr,
  output logic [15:0] operand_value,
  output logic value_valid,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic ext_fetch,
  output logic rom_sel,
  output logic ram_sel,
  input wire logic [IO_WIDTH-1:0] io_in_pins,
  input wire logic clock_tick,
  input wire logic clock_route_en,
  output logic [IO_WIDTH-1:0] io_in,
  output logic [IO_WIDTH-1:0] io_out_pins,
  input wire logic [IO_WIDTH-1:0] io_out_data,
  input wire logic io_out_load
);
  oag_pkg::oag_state_e state, next_state;
  logic [1:0] md, next_md;
  logic [3:0] rs, next_rs;
  logic bop, next_bop, imm, next_imm;
  logic [15:0] regval, next_regval;
  logic [15:0] next_operand_addr, next_operand_value, next_mem_addr, next_mem_wdata;
  logic next_addr_valid, next_value_valid, next_mem_rd, next_mem_wr, next_ext_fetch;
  logic [IO_WIDTH-1:0] in_s1, in_s2, next_io_out, next_io_in;
  logic clk_s1, clk_s2;
  logic [15:0] reg_loc, sext_off;

  assign reg_loc = 16'(workspace_ptr + {11'h000, rs, 1'b0});
  assign sext_off = {{8{relative_offset[7]}}, relative_offset};
  assign busy = (state != oag_pkg::OAG_IDLE);

  always_comb begin
    next_state = state;
    next_md = md;
    next_rs = rs;
    next_bop = bop;
    next_imm = imm;
    next_regval = regval;
    next_operand_addr = operand_addr;
    next_operand_value = operand_value;
    next_addr_valid = addr_valid;
    next_value_valid = value_valid;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_ext_fetch = 1'b0;
    done = 1'b0;
    case (state)
      oag_pkg::OAG_IDLE: begin
        if (req) begin
          next_md = mode;
          next_rs = reg_sel;
          next_bop = byte_op;
          next_imm = immediate;
          next_addr_valid = 1'b0;
          next_value_valid = 1'b0;
          if (jump) begin
            next_operand_addr = 16'(program_counter + {sext_off[14:0], 1'b0});
            next_addr_valid = 1'b1;
            next_state = oag_pkg::OAG_DONE;
          end else if (bit_io) begin
            next_operand_addr = 16'(base_addr + sext_off);
            next_addr_valid = 1'b1;
            next_state = oag_pkg::OAG_DONE;
          end else if (immediate ||
              (mode == oag_pkg::MODE_IDX && reg_sel == oag_pkg::REG_ZERO)) begin
            next_mem_rd = 1'b1;
            next_ext_fetch = 1'b1;
            next_mem_addr = program_counter;
            next_state = oag_pkg::OAG_RDEXT;
          end else begin
            next_mem_rd = 1'b1;
            next_mem_addr = 16'(workspace_ptr + {11'h000, reg_sel, 1'b0});
            next_state = oag_pkg::OAG_RDREG;
          end
        end
      end
      oag_pkg::OAG_RDREG: begin
        if (rd_valid) begin
          next_regval = rd_data;
          case (md)
            oag_pkg::MODE_REG: begin
              next_operand_value = rd_data;
              next_operand_addr = reg_loc;
              next_value_valid = 1'b1;
              next_state = oag_pkg::OAG_DONE;
            end
            oag_pkg::MODE_IND: begin
              next_operand_addr = rd_data;
              next_addr_valid = 1'b1;
              next_state = oag_pkg::OAG_DONE;
            end
            oag_pkg::MODE_IDX: begin
              next_mem_rd = 1'b1;
              next_ext_fetch = 1'b1;
              next_mem_addr = program_counter;
              next_state = oag_pkg::OAG_RDEXT;
            end
            default: begin
              next_operand_addr = rd_data;
              next_addr_valid = 1'b1;
              next_mem_wr = 1'b1;
              next_mem_addr = reg_loc;
              next_mem_wdata = 16'(rd_data + (bop ? oag_pkg::BYTE_STEP : oag_pkg::WORD_STEP));
              next_state = oag_pkg::OAG_WBREG;
            end
          endcase
        end
      end
      oag_pkg::OAG_RDEXT: begin
        if (rd_valid) begin
          if (imm) begin
            next_operand_value = rd_data;
            next_value_valid = 1'b1;
          end else if (md == oag_pkg::MODE_IDX && rs != oag_pkg::REG_ZERO) begin
            next_operand_addr = 16'(rd_data + regval);
            next_addr_valid = 1'b1;
          end else begin
            next_operand_addr = rd_data;
            next_addr_valid = 1'b1;
          end
          next_state = oag_pkg::OAG_DONE;
        end
      end
      oag_pkg::OAG_WBREG: next_state = oag_pkg::OAG_DONE;
      default: begin
        done = 1'b1;
        next_state = oag_pkg::OAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= oag_pkg::OAG_IDLE;
      md <= oag_pkg::MODE_REG;
      rs <= oag_pkg::REG_ZERO;
      bop <= 1'b0;
      imm <= 1'b0;
      regval <= 16'h0000;
      operand_addr <= 16'h0000;
      operand_value <= 16'h0000;
      addr_valid <= 1'b0;
      value_valid <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      ext_fetch <= 1'b0;
    end else begin
      state <= next_state;
      md <= next_md;
      rs <= next_rs;
      bop <= next_bop;
      imm <= next_imm;
      regval <= next_regval;
      operand_addr <= next_operand_addr;
      operand_value <= next_operand_value;
      addr_valid <= next_addr_valid;
      value_valid <= next_value_valid;
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      ext_fetch <= next_ext_fetch;
    end
  end

  // memory placement decode for the bus address
  always_comb begin
    rom_sel = 1'b0;
    ram_sel = 1'b0;
    if (mem_addr >= oag_pkg::ROM_BASE) begin
      rom_sel = 1'b1;
    end else if (mem_addr >= oag_pkg::RAM_BASE) begin
      ram_sel = 1'b1;
    end
  end

  // discrete i/o: inputs synchronised, input two optionally the clock
  always_comb begin
    next_io_out = io_out_load ? io_out_data : io_out_pins;
    next_io_in = in_s2;
    if (clock_route_en) begin
      next_io_in[oag_pkg::CLOCK_BIT] = clk_s2;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      io_out_pins <= '0;
      io_in <= '0;
    end else begin
      in_s1 <= io_in_pins;
      in_s2 <= in_s1;
      clk_s1 <= clock_tick;
      clk_s2 <= clk_s1;
      io_out_pins <= next_io_out;
      io_in <= next_io_in;
    end
  end
endmodule

// ==== verif/oag_mem_model.sv ====
// Purpose: memory answering reads of the generator
// Assumes: word at address a holds a ^ 3c3c
// Notes: latency alternates between two and five cycles
`timescale 1ns/1ps
module oag_mem_model (
  input logic mclk,
  input logic resetn,
  input logic mem_rd,
  input logic [15:0] mem_addr,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  logic [2:0] cnt;
  logic slow;
  logic [15:0] a;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) {cnt, slow, a, rd_valid, rd_data} <= '0;
    else begin
      rd_valid <= cnt == 3'h1;
      // inverse of last value between answers
      rd_data <= cnt == 3'h1 ? a ^ 16'h3c3c : ~rd_data;
      cnt <= mem_rd ? {slow, 1'b0, !slow} : cnt - 3'(cnt != 3'h0);
      slow <= slow ^ mem_rd;
      a <= mem_rd ? mem_addr : a;
    end
  end
endmodule

// ==== verif/oag_operand_address_generator_bench.sv ====
// Purpose: scenario bench for the address generator
// Assumes: memory word at a holds a ^ 3c3c
// Notes: one request at a time
`timescale 1ns/1ps
module oag_operand_address_generator_bench;
  logic mclk = 0, resetn = 0, req = 0, byte_op = 0, immediate = 0, jump = 0, bit_io = 0;
  logic clock_tick = 0, clock_route_en = 0, io_out_load = 0, rd_valid, busy, done, mem_rd;
  logic addr_valid, value_valid, mem_wr, ext_fetch, rom_sel, ram_sel;
  logic [1:0] mode = 0;
  logic [3:0] reg_sel = 0;
  logic [7:0] relative_offset = 0;
  logic [15:0] workspace_ptr = 16'hfbfe, program_counter = 16'h0200, base_addr = 16'h0040;
  logic [15:0] io_in_pins = 0, io_out_data = 0, operand_addr, operand_value, mem_addr;
  logic [15:0] mem_wdata, rd_data, io_in, io_out_pins, wd;
  localparam logic [15:0] K = 16'h3c3c;
  int miscompares = 0, compares = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (mem_wr) wd <= mem_wdata;
  oag_operand_address_generator dut_u (.*);
  oag_mem_model mem_u (.*);
  function automatic logic [15:0] w(logic [3:0] n);
    return (workspace_ptr + {11'h0, n, 1'b0}) ^ K;
  endfunction
  task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
    compares++;
    miscompares += 32'(seen !== exp);
    if (seen !== exp) $display("[FAIL] %s expected %h seen %h", s, exp, seen);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(logic [1:0] m, logic [3:0] r, logic [2:0] k, logic [7:0] o, logic b);
    int n;
    @(posedge mclk);
    {mode, reg_sel, jump, bit_io} <= {m, r, k[2:1]};
    {immediate, relative_offset, byte_op, req} <= {k[0], o, b, 1'b1};
    @(posedge mclk);
    req <= 0;
    #1;
    for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge mclk) #1;
    miscompares += 32'(n == 40);
    if (n == 40) tally_and_finish();
  endtask
  task automatic t_modes();
    op(oag_pkg::MODE_REG, 4'h1, 3'h0, 8'h0, 1'b0);
    chk("reg", operand_value, w(4'h1));
    chk("loc", operand_addr, w(4'h1) ^ K);
    chk("regv", 16'(value_valid), 16'h0001);
    chk("rom", 16'(rom_sel), 16'h0001);
    op(oag_pkg::MODE_IND, 4'h2, 3'h0, 8'h0, 1'b0);
    chk("ind", operand_addr, w(4'h2));
    chk("inda", 16'(addr_valid), 16'h0001);
    chk("indv", 16'(value_valid), 16'h0000);
    op(oag_pkg::MODE_IDX, 4'h3, 3'h0, 8'h0, 1'b0);
    chk("idx", operand_addr, w(4'h3) + (program_counter ^ K));
    op(oag_pkg::MODE_IDX, 4'h0, 3'h0, 8'h0, 1'b0);
    chk("dir", operand_addr, program_counter ^ K);
    chk("ram", 16'(ram_sel), 16'h0001);
    chk("norom", 16'(rom_sel), 16'h0000);
    op(oag_pkg::MODE_REG, 4'h0, 3'h1, 8'h0, 1'b0);
    chk("imm", operand_value, program_counter ^ K);
    chk("immv", 16'(value_valid), 16'h0001);
    $display("test modes done");
  endtask
  task automatic t_inc();
    for (int b = 0; b < 2; b++) begin
      op(oag_pkg::MODE_INC, 4'hf, 3'h0, 8'h0, b[0]);
      chk("inc", operand_addr, w(4'hf));
      chk("step", wd, w(4'hf) + (b[0] ? 16'h1 : 16'h2));
    end
    $display("test inc done");
  endtask
  task automatic t_rel();
    for (int i = 0; i < 2; i++) begin
      op(2'h0, 4'h0, i[0] ? 3'h7 : 3'h4, i[0] ? 8'h7f : 8'h80, 1'b0);
      chk("jump", operand_addr, program_counter + (i[0] ? 16'h00fe : 16'hff00));
    end
    op(2'h0, 4'h0, 3'h2, 8'hff, 1'b0);
    chk("bit", operand_addr, base_addr - 16'h1);
    $display("test rel done");
  endtask
  task automatic t_io();
    @(posedge mclk);
    {io_out_data, io_out_load} <= {16'ha55a, 1'b1};
    {io_in_pins, clock_tick, clock_route_en} <= {16'h1230, 1'b1, 1'b0};
    @(posedge mclk);
    io_out_load <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("out", io_out_pins, 16'ha55a);
    chk("in", io_in, 16'h1230);
    @(posedge mclk);
    clock_route_en <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("tick", io_in, 16'h1234);
    @(posedge mclk);
    {io_in_pins, clock_tick} <= {16'h1234, 1'b0};
    repeat (4) @(posedge mclk);
    #1;
    chk("no tick", io_in, 16'h1230);
    $display("test io done");
  endtask
  task automatic t_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rst out", io_out_pins, 16'h0000);
    chk("rst in", io_in, 16'h0000);
    chk("rst addr", operand_addr, 16'h0000);
    chk("rst valid", 16'(addr_valid), 16'h0000);
    @(posedge mclk);
    resetn <= 1'b1;
    op(oag_pkg::MODE_IDX, 4'h0, 3'h0, 8'h0, 1'b0);
    chk("dir again", operand_addr, program_counter ^ K);
    $display("test reset done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1;
    t_modes();
    t_inc();
    t_rel();
    t_io();
    t_reset();
    tally_and_finish();
  end
endmodule

// ==== verif/oag_properties.sv ====
// Purpose: port assertions for the address generator
// Assumes: request inputs stay stable while busy
// Notes: bound to every generator instance
`timescale 1ns/1ps
module oag_properties (
  input logic mclk,
  input logic resetn,
  input logic req,
  input logic busy,
  input logic done,
  input logic jump,
  input logic bit_io,
  input logic addr_valid,
  input logic mem_rd,
  input logic ext_fetch,
  input logic rom_sel,
  input logic ram_sel,
  input logic [7:0] relative_offset,
  input logic [15:0] program_counter,
  input logic [15:0] base_addr,
  input logic [15:0] operand_addr,
  input logic [15:0] mem_addr
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire take = req && !busy;
  jump_addr_a: assert property (take && jump |-> ##[1:2] addr_valid && operand_addr ==
    program_counter + {{7{relative_offset[7]}}, relative_offset, 1'b0}) else $error("jump");
  bit_addr_a: assert property (take && !jump && bit_io |-> ##[1:2] addr_valid &&
    operand_addr == base_addr + {{8{relative_offset[7]}}, relative_offset}) else $error("bit");
  rel_no_read_a: assert property (take && (jump || bit_io) |=> !mem_rd [*2])
    else $error("read in relative mode");
  ext_word_a: assert property (ext_fetch |-> mem_rd && mem_addr == program_counter)
    else $error("extension word");
  rom_decode_a: assert property (rom_sel == (mem_addr >= oag_pkg::ROM_BASE) &&
    ram_sel != rom_sel) else $error("decode");
  read_pulse_a: assert property (mem_rd |=> !mem_rd) else $error("read strobe");
  done_idle_a: assert property (done |=> !busy && !done) else $error("done");
  take_busy_a: assert property (take |=> busy) else $error("request lost");
  cover property (take && jump);
  cover property (ext_fetch);
  cover property (take && !jump && !bit_io);
endmodule
bind oag_operand_address_generator oag_properties chk_u (.*);
